/* File: design/eeprom_slave_pkg.sv */
// shared constants and types for the two-wire eeprom slave
package eeprom_slave_pkg;

	// ==========================================
	// clock and write cycle timing
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned T_WR_STD_MS     = 10;
	localparam int unsigned T_WR_LV_MS      = 15;
	localparam int unsigned WR_CYC_STD      = T_WR_STD_MS * (CLK_HZ / 1000);
	localparam int unsigned WR_CYC_LV       = T_WR_LV_MS * (CLK_HZ / 1000);
	localparam int unsigned TMR_W           = 20;

	// ==========================================
	// slave address layout
	localparam logic [3:0]  TYPE_ID         = 4'hA;
	localparam int unsigned TYPE_MSB        = 7;
	localparam int unsigned TYPE_LSB        = 4;
	localparam int unsigned CHIP_MSB        = 3;
	localparam int unsigned CHIP_LSB        = 1;
	localparam int unsigned RW_BIT          = 0;
	localparam int unsigned STRAP_W         = 3;

	// ==========================================
	// array organisation
	localparam int unsigned BYTE_W          = 8;
	localparam int unsigned ADDR_W          = 8;
	localparam int unsigned DEPTH           = 256;
	localparam int unsigned PAGE_W          = 4;
	localparam logic [3:0]  BIT_LAST        = 4'h7;
	localparam logic [3:0]  BIT_ACK         = 4'h8;

	// ==========================================
	// reset values
	localparam logic [7:0]  WORD_RST        = 8'h00;
	localparam logic [TMR_W-1:0] TMR_RST    = 20'h00000;

	// ==========================================
	// frame states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WORD,
		ST_WDATA,
		ST_RDATA,
		ST_WAIT
	} state_t;

endpackage

/* File: design/bit_link_if.sv */
// carrier between the serial clock shifter and the core
`timescale 1ns/1ns
interface bit_link_if;
	logic [7:0] word;	// last eight bits sampled
	logic       tgl;	// flips on each serial clock rise

	modport shifter (output word, output tgl);
	modport core    (input word, input tgl);
endinterface

/* File: design/scl_bit_shifter.sv */
// serial clock domain: samples the data line on each clock rise
`timescale 1ns/1ns
module scl_bit_shifter
	import eeprom_slave_pkg::*;
(
	input  wire logic          i_scl,
	input  wire logic          i_rst_b,
	input  wire logic          i_sda,
	bit_link_if.shifter        lnk
);

	logic [7:0] word;
	logic       tgl;
	logic [7:0] next_word;
	logic       next_tgl;

	// ==========================================
	// shift in one bit per rise, flag it by toggle
	always_comb begin
		next_word = {word[6:0], i_sda};
		next_tgl  = ~tgl;
	end

	always_ff @(posedge i_scl or negedge i_rst_b) begin
		if (!i_rst_b) begin
			word <= WORD_RST;
			tgl  <= 1'b0;
		end else begin
			word <= next_word;
			tgl  <= next_tgl;
		end
	end

	assign lnk.word = word;
	assign lnk.tgl  = tgl;

endmodule // scl_bit_shifter

/* File: design/serial_eeprom_bus_slave.sv */
// two-wire eeprom slave: framing, addressing, array and write cycle
// Summary of operation
// - after a write ends with stop, stay busy 10 ms, or 15 ms low-voltage
// - while busy, release the data line and never acknowledge own address
// - chip address comes from three static strap pins, eight chips per bus
// - one page block of 16 pages by 16 bytes, no block bits in address
// - a page is 16 consecutive bytes, all writable in one page write
// - every word is 8 bits and moves one byte at a time
// - transactions open with start, close with stop, receiver acks each byte
// - slave address recognised only when its top four bits equal 1010
// - last address bit picks direction: one reads, zero writes
// - on address match pull data low in the ack clock, else stay silent
`timescale 1ns/1ns
module serial_eeprom_bus_slave
	import eeprom_slave_pkg::*;
#(
	parameter logic            LOW_VCC  = 1'b0,
	parameter int unsigned     WR_STD   = WR_CYC_STD,
	parameter int unsigned     WR_LV    = WR_CYC_LV
)(
	input  wire logic               i_clk,
	input  wire logic               i_rst_b,
	input  wire logic               i_scl,
	input  wire logic               i_sda,
	input  wire logic [STRAP_W-1:0] i_chip_address_straps,
	output logic                    o_sda,
	output logic                    o_sda_oe_b,
	output logic                    o_busy
);

	localparam logic [TMR_W-1:0] WR_LOAD = LOW_VCC ? TMR_W'(WR_LV) : TMR_W'(WR_STD);

	bit_link_if lnk ();

	// ==========================================
	// serial clock domain
	scl_bit_shifter u_shift (
		.i_scl   (i_scl),
		.i_rst_b (i_rst_b),
		.i_sda   (i_sda),
		.lnk     (lnk.shifter)
	);

	// ==========================================
	// synchronisers for pins and the rise toggle
	logic [1:0]         scl_s;
	logic [1:0]         sda_s;
	logic [1:0]         tgl_s;
	logic [STRAP_W-1:0] strap_s1;
	logic [STRAP_W-1:0] strap_s2;
	logic               scl_d;
	logic               sda_d;
	logic               tgl_d;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_s    <= 2'h3;
			sda_s    <= 2'h3;
			tgl_s    <= 2'h0;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
			tgl_d    <= 1'b0;
		end else begin
			scl_s    <= {scl_s[0], i_scl};
			sda_s    <= {sda_s[0], i_sda};
			tgl_s    <= {tgl_s[0], lnk.tgl};
			strap_s1 <= i_chip_address_straps;
			strap_s2 <= strap_s1;
			scl_d    <= scl_s[1];
			sda_d    <= sda_s[1];
			tgl_d    <= tgl_s[1];
		end
	end

	// line events, only from second stage onward
	logic start_ev;
	logic stop_ev;
	logic fall_ev;
	logic rise_ev;

	assign start_ev = scl_s[1] && scl_d && sda_d && !sda_s[1];
	assign stop_ev  = scl_s[1] && scl_d && !sda_d && sda_s[1];
	assign fall_ev  = scl_d && !scl_s[1];
	assign rise_ev  = tgl_s[1] ^ tgl_d;

	// ==========================================
	// array storage, 256 bytes in flip-flops
	logic [BYTE_W-1:0] mem [DEPTH];
	logic              mem_we;
	logic [ADDR_W-1:0] mem_idx;
	logic [BYTE_W-1:0] mem_din;

	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			mem[mem_idx] <= mem_din;
		end
	end

	// ==========================================
	// frame state
	state_t            state;
	state_t            next_state;
	logic [3:0]        bit_cnt;
	logic [3:0]        next_bit_cnt;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic [BYTE_W-1:0] tx;
	logic [BYTE_W-1:0] next_tx;
	logic              ack;
	logic              next_ack;
	logic              rd;
	logic              next_rd;
	logic              written;
	logic              next_written;
	logic [TMR_W-1:0]  tmr;
	logic [TMR_W-1:0]  next_tmr;
	logic              busy;
	logic              next_busy;
	logic              oe_b;
	logic              next_oe_b;
	logic              match;

	assign match = (lnk.word[TYPE_MSB:TYPE_LSB] == TYPE_ID)
		&& (lnk.word[CHIP_MSB:CHIP_LSB] == strap_s2);

	always_comb begin
		next_state   = state;
		next_bit_cnt = bit_cnt;
		next_addr    = addr;
		next_tx      = tx;
		next_ack     = ack;
		next_rd      = rd;
		next_written = written;
		next_tmr     = tmr;
		next_busy    = busy;
		next_oe_b    = oe_b;
		mem_we       = 1'b0;
		mem_idx      = addr;
		mem_din      = lnk.word;

		if (busy) begin
			if (tmr == TMR_RST) begin
				next_busy = 1'b0;
			end else begin
				next_tmr = tmr - 1'b1;
			end
		end

		if (stop_ev) begin
			next_state = ST_IDLE;
			next_oe_b  = 1'b1;
			next_ack   = 1'b0;
			// stop after written data starts cycle
			if (written) begin
				next_busy    = 1'b1;
				next_tmr     = WR_LOAD;
				next_written = 1'b0;
			end
		end else if (start_ev) begin
			next_state   = ST_ADDR;
			next_bit_cnt = 4'h0;
			next_ack     = 1'b0;
			next_oe_b    = 1'b1;
		end else if (rise_ev && state != ST_IDLE) begin
			if (bit_cnt == BIT_LAST) begin
				next_bit_cnt = BIT_ACK;
				case (state)
					ST_ADDR: begin
						// busy: no acknowledge to own address
						if (match && !busy) begin
							next_ack = 1'b1;
							next_rd  = lnk.word[RW_BIT];
						end else begin
							next_state = ST_WAIT;
						end
					end
					ST_WORD: begin
						next_addr = lnk.word;
						next_ack  = 1'b1;
					end
					ST_WDATA: begin
						mem_we       = 1'b1;
						next_addr    = {addr[ADDR_W-1:PAGE_W], addr[PAGE_W-1:0] + 4'h1};
						next_ack     = 1'b1;
						next_written = 1'b1;
					end
					default: begin
					end
				endcase
			end else if (bit_cnt == BIT_ACK) begin
				next_bit_cnt = 4'h0;
				next_ack     = 1'b0;
				case (state)
					ST_ADDR: begin
						if (rd) begin
							next_state = ST_RDATA;
							next_tx    = mem[addr];
							next_addr  = addr + 8'h01;
						end else begin
							next_state = ST_WORD;
						end
					end
					ST_WORD: begin
						next_state = ST_WDATA;
					end
					ST_RDATA: begin
						if (!lnk.word[0]) begin
							next_tx   = mem[addr];
							next_addr = addr + 8'h01;
						end else begin
							next_state = ST_WAIT;
						end
					end
					default: begin
					end
				endcase
			end else begin
				next_bit_cnt = bit_cnt + 4'h1;
			end
		end else if (fall_ev) begin
			// pull low through the ack clock
			if (ack && bit_cnt == BIT_ACK) begin
				next_oe_b = 1'b0;
			end else if (state == ST_RDATA && bit_cnt != BIT_ACK) begin
				next_oe_b = tx[3'(BIT_LAST - bit_cnt)];
			end else begin
				next_oe_b = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state   <= ST_IDLE;
			bit_cnt <= 4'h0;
			addr    <= 8'h00;
			tx      <= WORD_RST;
			ack     <= 1'b0;
			rd      <= 1'b0;
			written <= 1'b0;
			tmr     <= TMR_RST;
			busy    <= 1'b0;
			oe_b    <= 1'b1;
		end else begin
			state   <= next_state;
			bit_cnt <= next_bit_cnt;
			addr    <= next_addr;
			tx      <= next_tx;
			ack     <= next_ack;
			rd      <= next_rd;
			written <= next_written;
			tmr     <= next_tmr;
			busy    <= next_busy;
			oe_b    <= next_oe_b;
		end
	end

	// ==========================================
	// outputs, all flop-driven
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sda      <= 1'b0;
			o_sda_oe_b <= 1'b1;
			o_busy     <= 1'b0;
		end else begin
			o_sda      <= 1'b0;	// open drain: only ever low
			o_sda_oe_b <= next_oe_b;
			o_busy     <= next_busy;
		end
	end

endmodule // serial_eeprom_bus_slave

/* File: sim/eeprom_slave_sva.sv */
// assertions on the eeprom slave pins
`timescale 1ns/1ns
module eeprom_slave_sva #(
	parameter logic        LOW_VCC = 1'b0,
	parameter int unsigned WR_STD  = 400,
	parameter int unsigned WR_LV   = 600
)(
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire logic       i_scl,
	input wire logic       i_sda,
	input wire logic [2:0] i_chip_address_straps,
	input wire logic       o_sda,
	input wire logic       o_sda_oe_b,
	input wire logic       o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	localparam int unsigned WR = LOW_VCC ? WR_LV : WR_STD;
	int unsigned cnt;
	int unsigned next_cnt;
	// ========================================
	// write cycle length counter
	always_comb next_cnt = o_busy ? cnt + 1 : 0;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			cnt <= 0;
		else
			cnt <= next_cnt;
	end
	sequence s_idle;
		i_scl && i_sda;
	endsequence
	sequence s_pull;
		$fell(o_sda_oe_b);
	endsequence
	a_sda_zero: assert property (o_sda == 1'b0) else $error("sda value not low");
	a_busy_quiet: assert property (o_busy |-> o_sda_oe_b) else $error("sda pulled while busy");
	a_busy_len: assert property ($fell(o_busy) |-> cnt == WR + 1) else $error("write cycle length");
	a_busy_max: assert property (cnt <= WR + 1) else $error("write cycle too long");
	a_busy_stop: assert property ($rose(o_busy) |-> s_idle) else $error("busy without stop");
	a_busy_free: assert property ($rose(o_busy) |-> $past(o_sda_oe_b)) else $error("busy during ack");
	a_oe_scl_low: assert property ($changed(o_sda_oe_b) |-> !i_scl) else $error("sda moved, scl high");
	a_ack_hold: assert property (s_pull |-> (!o_sda_oe_b) [*8]) else $error("ack too short");
endmodule // eeprom_slave_sva
bind serial_eeprom_bus_slave eeprom_slave_sva #(.LOW_VCC(LOW_VCC), .WR_STD(WR_STD), .WR_LV(WR_LV)) i_sva (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda(i_sda),
	.i_chip_address_straps(i_chip_address_straps), .o_sda(o_sda),
	.o_sda_oe_b(o_sda_oe_b), .o_busy(o_busy));

/* File: sim/i2c_master_model.sv */
// two-wire bus master model on its own link clock
`timescale 1ns/1ns
module i2c_master_model (
	input  wire logic i_lclk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_drv_b
);
	logic [7:0] obs;
	event       got;
	initial begin
		o_scl = 1'b1;
		o_sda_drv_b = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge i_lclk);
	endtask
	// one bit: data set in scl low, sampled mid high
	task automatic bit_x(input logic b, output logic r);
		o_sda_drv_b <= b;
		tk(10);
		o_scl <= 1'b1;
		tk(5);
		r = i_sda;
		tk(5);
		o_scl <= 1'b0;
		tk(1);
	endtask
	task automatic start;
		o_sda_drv_b <= 1'b1;
		tk(10);
		o_scl <= 1'b1;
		tk(10);
		o_sda_drv_b <= 1'b0;
		tk(10);
		o_scl <= 1'b0;
		tk(1);
	endtask
	task automatic stop;
		o_sda_drv_b <= 1'b0;
		tk(10);
		o_scl <= 1'b1;
		tk(10);
		o_sda_drv_b <= 1'b1;
		tk(20);
	endtask
	// byte out msb first, ack back
	task automatic send(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(b[i], r);
		bit_x(1'b1, r);
		obs = {7'h00, r};
		->got;
	endtask
	// byte in, then our ack bit
	task automatic recv(input logic a);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			obs[i] = r;
		end
		bit_x(a, r);
		->got;
	endtask
endmodule // i2c_master_model

/* File: sim/serial_eeprom_bus_slave_tb_top.sv */
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ns
module serial_eeprom_bus_slave_tb_top
	import eeprom_slave_pkg::*;
;
	logic       clk = 1'b0;
	logic       lclk = 1'b0;
	logic       rst_b = 1'b0;
	logic [2:0] straps = 3'h0;
	logic       scl, drv_b, sda_d, sda_oe_b, busy;
	wire        sda = drv_b & (sda_oe_b | sda_d);
	logic [7:0] q[$];
	logic [7:0] lfsr = 8'h1D;
	logic [7:0] d0, d1, ad;
	int         errors = 0;
	int         checks = 0;
	always #25 clk = ~clk;
	always #24 lclk = ~lclk;
	serial_eeprom_bus_slave #(.LOW_VCC(1'b0), .WR_STD(400), .WR_LV(600)) i_dut (
		.i_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda),
		.i_chip_address_straps(straps), .o_sda(sda_d), .o_sda_oe_b(sda_oe_b), .o_busy(busy));
	i2c_master_model i_mst (.i_lclk(lclk), .i_sda(sda), .o_scl(scl), .o_sda_drv_b(drv_b));
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tx(input logic [7:0] b, input logic [7:0] e);
		q.push_back(e);
		i_mst.send(b);
	endtask
	// point the address counter at word w, then read one byte back
	task automatic rd(input logic [7:0] w, input logic [7:0] e);
		i_mst.start();
		tx(ad, 8'h00);
		tx(w, 8'h00);
		i_mst.start();
		tx(ad | 8'h01, 8'h00);
		q.push_back(e);
		i_mst.recv(1'b1);
		// the read closes with a stop, the address write with a repeated start
		i_mst.stop();
	endtask
	// compare each result with the oldest note
	always @(i_mst.got) chk(i_mst.obs, q.pop_front());
	initial begin
		#2000000;
		errors++;
		end_sim();
	end
	initial begin
		int n;
		@(posedge clk);
		lfsr = nx(lfsr);
		// a single 2K chip on the bus, well under 16K in total
		straps <= lfsr[2:0];
		d0 = nx(lfsr);
		d1 = nx(d0);
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		ad = {TYPE_ID, lfsr[2:0], 1'b0};
		// page write over the page end
		i_mst.start();
		tx(ad, 8'h00);
		tx(8'h3F, 8'h00);
		tx(d0, 8'h00);
		tx(d1, 8'h00);
		i_mst.stop();
		$display("page write done");
		// poll during the write cycle
		i_mst.start();
		tx(ad, 8'h01);
		i_mst.stop();
		n = 0;
		while (busy !== 1'b0 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, busy}, 8'h00);
		$display("poll done");
		// second byte rolled to the page start
		rd(8'h3F, d0);
		rd(8'h30, d1);
		$display("read back done");
		// foreign type code, then foreign chip bits
		i_mst.start();
		tx({4'hB, lfsr[2:0], 1'b0}, 8'h01);
		i_mst.start();
		tx({TYPE_ID, ~lfsr[2:0], 1'b0}, 8'h01);
		i_mst.start();
		tx({TYPE_ID, lfsr[2:0] ^ 3'h1, 1'b0}, 8'h01);
		i_mst.stop();
		$display("mismatch done");
		end_sim();
	end
endmodule // serial_eeprom_bus_slave_tb_top
